// file: common/dmsr_pkg.sv
package dmsr_pkg;

  // ****************************************
  // Register selects on the internal data bus
  // ****************************************
  typedef enum logic [2:0] {
    SEL_MODE   = 3'h0,
    SEL_STATUS = 3'h1,
    SEL_IRQ_EN = 3'h2,
    SEL_WAIT   = 3'h3,
    SEL_XSHIFT = 3'h4,
    SEL_IMR    = 3'h5
  } dmsr_sel_t;

  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic       global_irq_enable;
    logic       ext_int_mask;
    logic       group_a_port_irq_enable;
    logic       group_b_port_irq_enable;
    logic [1:0] rsv;
    logic       vector_block_in_ram;
    logic       checksum_clear_trigger;
    logic       group_a_sync_type;
    logic       group_b_sync_type;
    logic       port_grouping_select;
    logic       group_a_precision_hi;
    logic       group_b_precision_hi;
    logic       vector_map_select;
    logic [1:0] wait_sel;
    logic       multiplier_shift;
    logic [1:0] transfer_shift_select;
    logic       shift_direction;
  } dmsr_cfg_t;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic       audio_pll_locked;
    logic       par_mem_strap;
    logic       saved_irq_enable;
    logic       core_pll_locked;
    logic       rsv_lo;
    logic       host_write_cause;
    logic       group_a_channel_side;
    logic       group_b_channel_side;
    logic       quotient;
    logic       sticky_scale_flag;
    logic       sticky_limit_flag;
    logic       sticky_overflow_flag;
    logic       overflow;
    logic       carry;
    logic       negative;
    logic       zero;
  } dmsr_status_t;

  // Arithmetic unit result flags
  typedef struct packed {
    logic upd;
    logic compare;
    logic quotient;
    logic overflow;
    logic carry;
    logic negative;
    logic zero;
  } dmsr_alu_t;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    dmsr_sel_t  sel;
    logic [19:0] wdata;
  } dmsr_bus_req_t;

  // ****************************************
  // Widths, positions, masks, reset values
  // ****************************************
  localparam int unsigned REG_W = 20;
  localparam logic [19:0] MODE_RST = 20'h00000;
  localparam logic [19:0] MODE_WMASK = 20'hf3fff;
  localparam logic [19:0] STATUS_WMASK = 20'h000ff;
  localparam logic [19:0] STATUS_ROMASK = 20'h0f7ff;
  localparam int unsigned IMR_LSB = 16;
  localparam int unsigned IRQ_EN_POS = 19;
  localparam logic [19:0] SCALE_LIMIT = 20'h20000;
  localparam logic [2:0] STRAP_SETTLE = 3'h5;
  localparam logic [4:0] WORD_BITS_20 = 5'h14;
  localparam logic [4:0] WORD_BITS_18 = 5'h12;
  localparam logic [4:0] WORD_BITS_16 = 5'h10;
  localparam logic [4:0] WORD_BITS_24 = 5'h18;
  localparam logic [6:0] GROUP_B_PORTS_WITH_F = 7'h6e;
  localparam logic [6:0] GROUP_B_PORTS_NO_F = 7'h4e;

endpackage

// file: design/dmsr_regs.sv
// Behaviour
// - Interrupts pass only while the global enable is set.
// - Three mask bits enable external, group A and group B interrupts.
// - Program memory bit places the vector block in internal RAM.
// - Rising checksum trigger clears the accumulator next cycle; trigger clears at reset.
// - Per group sync type: set means word select, clear means frame sync.
// - Grouping bit moves port F between group A and group B.
// - Word precision pair: 00=20, 01=18, 10=16, 11=24 bits.
// - Vector location from map bit, map pin and program memory bit.
// - Wait field codes give 0, 1, 3 or 7 wait states.
// - Multiplier shift bit selects one-bit left arithmetic shift.
// - Transfer shift field: none, left one, left two, right one.
// - Shift direction bit flips the sense of positive shift codes.
// - Audio PLL reset request clears audio lock until relock.
// - Core PLL reset request clears core lock until relock.
// - Read-only flag holds strap pin level captured at reset.
// - Interrupt entry saves global enable and clears it together.
// - Host write flag set when host interrupt came from a write.
// - Per group channel flag: clear for left, set for right.
// - Sticky scaling flag set on transfer magnitude above 0.25.
// - Sticky limiting flag set on any limiting, cleared by reset or clear.
// - Sticky overflow follows overflow except on compares.
// - Overflow, carry, negative and zero updated on each result.
// - Interrupt mask register copy always equals the mode bits.
module dmsr_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire dmsr_pkg::dmsr_bus_req_t bus_req_in,
  output logic [19:0] bus_rdata_out,
  input wire logic irq_entry_in,
  input wire logic ext_irq_req_in,
  input wire logic group_a_irq_req_in,
  input wire logic group_b_irq_req_in,
  output logic [2:0] irq_take_out,
  input wire dmsr_pkg::dmsr_alu_t alu_in,
  input wire logic xfer_valid_in,
  input wire logic [19:0] xfer_word_in,
  input wire logic limit_event_in,
  input wire logic sticky_clear_in,
  input wire logic host_write_event_in,
  input wire logic host_irq_ack_in,
  input wire logic group_a_channel_side_in,
  input wire logic group_b_channel_side_in,
  input wire logic group_a_precision_lo_in,
  input wire logic group_b_precision_lo_in,
  input wire logic audio_pll_reset_req_in,
  input wire logic core_pll_reset_req_in,
  input wire logic audio_pll_lock_pin_in,
  input wire logic core_pll_lock_pin_in,
  input wire logic par_mem_strap_pin_in,
  input wire logic vector_map_pin_in,
  output dmsr_pkg::dmsr_cfg_t cfg_out,
  output dmsr_pkg::dmsr_status_t status_out,
  output logic checksum_clear_out,
  output logic [2:0] vector_loc_out,
  output logic group_a_word_sync_out,
  output logic group_b_word_sync_out,
  output logic [6:0] port_in_group_b_out,
  output logic [4:0] group_a_word_bits_out,
  output logic [4:0] group_b_word_bits_out,
  output logic [2:0] wait_states_out,
  output logic [1:0] xfer_shift_left_out,
  output logic xfer_shift_right_out,
  output logic audio_pll_reset_out,
  output logic core_pll_reset_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pin_sync;

  dmsr_sync3 #(.W(4)) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in({audio_pll_lock_pin_in, core_pll_lock_pin_in, par_mem_strap_pin_in,
               vector_map_pin_in}),
    .sync_out(pin_sync)
  );

  // ****************************************
  // Write decode
  // ****************************************
  logic wr_mode;
  logic wr_status;
  logic wr_irq_en;
  logic wr_wait;
  logic wr_xshift;
  logic wr_imr;
  logic [19:0] wd;

  always_comb begin
    wd = bus_req_in.wdata;
    wr_mode = 1'b0;
    wr_status = 1'b0;
    wr_irq_en = 1'b0;
    wr_wait = 1'b0;
    wr_xshift = 1'b0;
    wr_imr = 1'b0;
    if (bus_req_in.wr && bus_req_in.sel == dmsr_pkg::SEL_MODE) begin
      wr_mode = 1'b1;
    end else if (bus_req_in.wr && bus_req_in.sel == dmsr_pkg::SEL_STATUS) begin
      wr_status = 1'b1;
    end else if (bus_req_in.wr && bus_req_in.sel == dmsr_pkg::SEL_IRQ_EN) begin
      wr_irq_en = 1'b1;
    end else if (bus_req_in.wr && bus_req_in.sel == dmsr_pkg::SEL_WAIT) begin
      wr_wait = 1'b1;
    end else if (bus_req_in.wr && bus_req_in.sel == dmsr_pkg::SEL_XSHIFT) begin
      wr_xshift = 1'b1;
    end else if (bus_req_in.wr && bus_req_in.sel == dmsr_pkg::SEL_IMR) begin
      wr_imr = 1'b1;
    end
  end

  // ****************************************
  // Configuration register
  // ****************************************
  dmsr_pkg::dmsr_cfg_t cfg_q;
  dmsr_pkg::dmsr_cfg_t cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_mode) begin
      cfg_d = dmsr_pkg::dmsr_cfg_t'(wd & dmsr_pkg::MODE_WMASK);
    end
    if (wr_imr) begin
      {cfg_d.global_irq_enable, cfg_d.ext_int_mask, cfg_d.group_a_port_irq_enable,
       cfg_d.group_b_port_irq_enable} = wd[dmsr_pkg::IMR_LSB +: 4];
    end
    if (wr_irq_en) begin
      cfg_d.global_irq_enable = wd[0];
    end
    if (wr_wait) begin
      cfg_d.wait_sel = wd[1:0];
    end
    if (wr_xshift) begin
      cfg_d.transfer_shift_select = wd[1:0];
    end
    if (irq_entry_in) begin
      cfg_d.global_irq_enable = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_q <= dmsr_pkg::dmsr_cfg_t'(dmsr_pkg::MODE_RST);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************
  // Interrupt gating
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_take_out <= 3'h0;
    end else begin
      irq_take_out <= {3{cfg_q.global_irq_enable}} &
                      {ext_irq_req_in & cfg_q.ext_int_mask,
                       group_a_irq_req_in & cfg_q.group_a_port_irq_enable,
                       group_b_irq_req_in & cfg_q.group_b_port_irq_enable};
    end
  end

  // ****************************************
  // Checksum clear edge
  // ****************************************
  logic crc_prev_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crc_prev_q <= 1'b0;
      checksum_clear_out <= 1'b0;
    end else begin
      crc_prev_q <= cfg_q.checksum_clear_trigger;
      checksum_clear_out <= cfg_q.checksum_clear_trigger & ~crc_prev_q;
    end
  end

  // ****************************************
  // Decoded controls
  // ****************************************
  function automatic logic [4:0] word_bits(input logic hi, input logic lo);
    logic [4:0] r;
    r = dmsr_pkg::WORD_BITS_20;
    case ({hi, lo})
      2'b00: r = dmsr_pkg::WORD_BITS_20;
      2'b01: r = dmsr_pkg::WORD_BITS_18;
      2'b10: r = dmsr_pkg::WORD_BITS_16;
      default: r = dmsr_pkg::WORD_BITS_24;
    endcase
    return r;
  endfunction

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_out <= dmsr_pkg::dmsr_cfg_t'(dmsr_pkg::MODE_RST);
      vector_loc_out <= 3'h0;
      group_a_word_sync_out <= 1'b0;
      group_b_word_sync_out <= 1'b0;
      port_in_group_b_out <= dmsr_pkg::GROUP_B_PORTS_NO_F;
      group_a_word_bits_out <= dmsr_pkg::WORD_BITS_20;
      group_b_word_bits_out <= dmsr_pkg::WORD_BITS_20;
      wait_states_out <= 3'h0;
      xfer_shift_left_out <= 2'h0;
      xfer_shift_right_out <= 1'b0;
    end else begin
      // multiplier shift and direction travel in cfg_out
      cfg_out <= cfg_q;
      // map bit, pin and program memory bit
      vector_loc_out <= {cfg_q.vector_block_in_ram, pin_sync[0], cfg_q.vector_map_select};
      group_a_word_sync_out <= cfg_q.group_a_sync_type;
      group_b_word_sync_out <= cfg_q.group_b_sync_type;
      port_in_group_b_out <= cfg_q.port_grouping_select ? dmsr_pkg::GROUP_B_PORTS_WITH_F :
                             dmsr_pkg::GROUP_B_PORTS_NO_F;
      group_a_word_bits_out <= word_bits(cfg_q.group_a_precision_hi, group_a_precision_lo_in);
      group_b_word_bits_out <= word_bits(cfg_q.group_b_precision_hi, group_b_precision_lo_in);
      wait_states_out <= (3'h1 << cfg_q.wait_sel) - 3'h1;
      xfer_shift_left_out <= (cfg_q.transfer_shift_select == 2'h3) ? 2'h0 :
                             cfg_q.transfer_shift_select;
      xfer_shift_right_out <= (cfg_q.transfer_shift_select == 2'h3);
    end
  end

  // ****************************************
  // PLL lock and strap
  // ****************************************
  logic [2:0] strap_cnt_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      audio_pll_reset_out <= 1'b0;
      core_pll_reset_out <= 1'b0;
      status_out.audio_pll_locked <= 1'b0;
      status_out.core_pll_locked <= 1'b0;
    end else begin
      audio_pll_reset_out <= audio_pll_reset_req_in;
      core_pll_reset_out <= core_pll_reset_req_in;
      status_out.audio_pll_locked <= ~audio_pll_reset_req_in & pin_sync[3];
      status_out.core_pll_locked <= ~core_pll_reset_req_in & pin_sync[2];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_cnt_q <= 3'h0;
      status_out.par_mem_strap <= 1'b0;
    end else if (strap_cnt_q != dmsr_pkg::STRAP_SETTLE) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      status_out.par_mem_strap <= pin_sync[1];
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic scale_hit;
  logic ovf_set;

  always_comb begin
    scale_hit = xfer_valid_in &&
                (($signed(xfer_word_in) > $signed(dmsr_pkg::SCALE_LIMIT)) ||
                 ($signed(xfer_word_in) < -$signed(dmsr_pkg::SCALE_LIMIT)));
    ovf_set = alu_in.upd && alu_in.overflow && !alu_in.compare;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out.rsv_hi <= 4'h0;
      status_out.rsv_lo <= 1'b0;
      status_out.saved_irq_enable <= 1'b0;
      status_out.host_write_cause <= 1'b0;
      status_out.group_a_channel_side <= 1'b0;
      status_out.group_b_channel_side <= 1'b0;
    end else begin
      status_out.rsv_hi <= 4'h0;
      status_out.rsv_lo <= 1'b0;
      if (irq_entry_in) begin
        status_out.saved_irq_enable <= cfg_q.global_irq_enable;
      end
      if (host_write_event_in) begin
        status_out.host_write_cause <= 1'b1;
      end else if (host_irq_ack_in) begin
        status_out.host_write_cause <= 1'b0;
      end
      status_out.group_a_channel_side <= group_a_channel_side_in;
      status_out.group_b_channel_side <= group_b_channel_side_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out.sticky_scale_flag <= 1'b0;
      status_out.sticky_limit_flag <= 1'b0;
      status_out.sticky_overflow_flag <= 1'b0;
    end else begin
      if (wr_status) begin
        status_out.sticky_scale_flag <= wd[6];
        status_out.sticky_limit_flag <= wd[5];
        status_out.sticky_overflow_flag <= wd[4];
      end else if (sticky_clear_in) begin
        status_out.sticky_scale_flag <= 1'b0;
        status_out.sticky_limit_flag <= 1'b0;
        status_out.sticky_overflow_flag <= 1'b0;
      end
      if (scale_hit) begin
        status_out.sticky_scale_flag <= 1'b1;
      end
      if (limit_event_in) begin
        status_out.sticky_limit_flag <= 1'b1;
      end
      if (ovf_set) begin
        status_out.sticky_overflow_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {status_out.quotient, status_out.overflow, status_out.carry, status_out.negative,
       status_out.zero} <= 5'h00;
    end else if (alu_in.upd) begin
      {status_out.quotient, status_out.overflow, status_out.carry, status_out.negative,
       status_out.zero} <= {alu_in.quotient, alu_in.overflow, alu_in.carry,
                            alu_in.negative, alu_in.zero};
    end else if (wr_status) begin
      {status_out.quotient, status_out.overflow, status_out.carry, status_out.negative,
       status_out.zero} <= {wd[7], wd[3:0]};
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_rdata_out <= 20'h00000;
    end else if (bus_req_in.rd) begin
      if (bus_req_in.sel == dmsr_pkg::SEL_MODE) begin
        bus_rdata_out <= cfg_q & dmsr_pkg::MODE_WMASK;
      end else if (bus_req_in.sel == dmsr_pkg::SEL_STATUS) begin
        bus_rdata_out <= status_out & dmsr_pkg::STATUS_ROMASK;
      end else if (bus_req_in.sel == dmsr_pkg::SEL_IRQ_EN) begin
        bus_rdata_out <= {19'h00000, cfg_q.global_irq_enable};
      end else if (bus_req_in.sel == dmsr_pkg::SEL_WAIT) begin
        bus_rdata_out <= {18'h00000, cfg_q.wait_sel};
      end else if (bus_req_in.sel == dmsr_pkg::SEL_XSHIFT) begin
        bus_rdata_out <= {18'h00000, cfg_q.transfer_shift_select};
      end else if (bus_req_in.sel == dmsr_pkg::SEL_IMR) begin
        bus_rdata_out <= {cfg_q[dmsr_pkg::IRQ_EN_POS -: 4], 16'h0000};
      end else begin
        bus_rdata_out <= 20'h00000;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_crc_rise;
    !cfg_q.checksum_clear_trigger ##1 cfg_q.checksum_clear_trigger;
  endsequence

  a_irq_global_gate: assert property (
    |irq_take_out |-> $past(cfg_q.global_irq_enable))
    else $error("Interrupt passed with global enable clear");

  a_irq_ext_mask: assert property (
    irq_take_out[2] |-> $past(cfg_q.ext_int_mask && ext_irq_req_in))
    else $error("External interrupt passed while masked");

  a_crc_clear_pulse: assert property (
    s_crc_rise |=> checksum_clear_out ##1 !checksum_clear_out)
    else $error("Checksum clear pulse missing or too long");

  a_mode_zero_bits: assert property (
    cfg_q.rsv == 2'h0 && status_out.rsv_hi == 4'h0)
    else $error("Reserved bit became nonzero");

  a_wait_seven: assert property (
    cfg_q.wait_sel == 2'h3 |=> wait_states_out == 3'h7)
    else $error("Wait code three did not give seven");

  a_entry_saves_ie: assert property (
    irq_entry_in |=> !cfg_q.global_irq_enable &&
                     status_out.saved_irq_enable == $past(cfg_q.global_irq_enable))
    else $error("Interrupt entry did not save and clear enable");

  a_audio_lock_reset: assert property (
    audio_pll_reset_req_in |=> !status_out.audio_pll_locked)
    else $error("Audio lock stayed set under reset request");

  a_overflow_sticky: assert property (
    ovf_set |=> status_out.sticky_overflow_flag [*2] or
               (status_out.sticky_overflow_flag ##1 1'b1))
    else $error("Sticky overflow not set after overflow");

  a_word_bits_24: assert property (
    cfg_q.group_a_precision_hi && group_a_precision_lo_in |=>
      group_a_word_bits_out == dmsr_pkg::WORD_BITS_24)
    else $error("Group A precision pair 11 not 24 bits");

  a_imr_mirror: assert property (
    bus_req_in.rd && bus_req_in.sel == dmsr_pkg::SEL_IMR |=>
      bus_rdata_out[19:16] == $past(cfg_q[19:16]))
    else $error("Mask register copy differs from mode bits");

  a_host_set_wins: assert property (
    host_write_event_in |=> status_out.host_write_cause)
    else $error("Host write cause lost");

endmodule // dmsr_regs

// file: design/dmsr_sync3.sv
module dmsr_sync3 #(
  parameter int unsigned W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ****************************************
  // Three-stage capture, accept when the last two stages agree
  // ****************************************
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          sync_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule // dmsr_sync3

// file: verif/dsp_mode_status_registers_tb.sv
module dsp_mode_status_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Stimulus, design and checking
  // ****************************************
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  dmsr_pkg::dmsr_bus_req_t bus_req_in = '0;
  dmsr_pkg::dmsr_alu_t alu_in = '0;
  logic irq_entry_in = 1'b0, ext_irq_req_in = 1'b0, group_a_irq_req_in = 1'b0;
  logic group_b_irq_req_in = 1'b0, xfer_valid_in = 1'b0, limit_event_in = 1'b0;
  logic sticky_clear_in = 1'b0, host_write_event_in = 1'b0, host_irq_ack_in = 1'b0;
  logic group_a_channel_side_in = 1'b1, group_b_channel_side_in = 1'b0;
  logic group_a_precision_lo_in = 1'b0, group_b_precision_lo_in = 1'b0;
  logic audio_pll_reset_req_in = 1'b0, core_pll_reset_req_in = 1'b0;
  logic audio_pll_lock_pin_in = 1'b1, core_pll_lock_pin_in = 1'b1;
  logic par_mem_strap_pin_in = 1'b1, vector_map_pin_in = 1'b1;
  logic [19:0] xfer_word_in = '0;
  logic [19:0] bus_rdata_out;
  logic [2:0] irq_take_out, vector_loc_out, wait_states_out;
  dmsr_pkg::dmsr_cfg_t cfg_out;
  dmsr_pkg::dmsr_status_t status_out;
  logic checksum_clear_out, group_a_word_sync_out, group_b_word_sync_out;
  logic xfer_shift_right_out, audio_pll_reset_out, core_pll_reset_out;
  logic [6:0] port_in_group_b_out;
  logic [4:0] group_a_word_bits_out, group_b_word_bits_out;
  logic [1:0] xfer_shift_left_out;
  logic [19:0] exp_q[$];
  logic [31:0] seed = 32'h24;
  logic [19:0] c;
  logic [4:0] wb[4] = '{5'h14, 5'h12, 5'h10, 5'h18};
  logic prev = 1'b0;
  int failures = 0;
  int n_tests = 0;

  dmsr_regs dut_u (.*);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request up; the caller releases it after the last one
  task automatic bus(input logic w, input logic [2:0] s, input logic [19:0] d,
                     input logic [19:0] e);
    bus_req_in.wr = w;
    bus_req_in.rd = !w;
    bus_req_in.sel = dmsr_pkg::dmsr_sel_t'(s);
    bus_req_in.wdata = d;
    if (!w) exp_q.push_back(e);
    @(posedge clk_in);
    #1;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    test_done;
  end

  // Read data lands on the same edge that takes the read
  always @(posedge clk_in) begin
    if (bus_req_in.rd === 1'b1) begin
      #2;
      if (exp_q.size() == 0) begin
        failures++;
        $display("[FAIL] %0t read with no note", $time);
      end else begin
        chk(bus_rdata_out, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    step(1);
    chk(cfg_out, 20'h0);
    chk(port_in_group_b_out, 7'h4e);
    chk(group_a_word_bits_out, 5'h14);
    step(5);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      c = seed[19:0] & dmsr_pkg::MODE_WMASK;
      {group_a_precision_lo_in, group_b_precision_lo_in} = seed[21:20];
      {ext_irq_req_in, group_a_irq_req_in, group_b_irq_req_in} = seed[24:22];
      bus(1'b1, 3'h0, seed[19:0], '0);
      bus(1'b0, 3'h0, '0, c);
      chk(checksum_clear_out, c[12] & ~prev);
      bus(1'b0, 3'h5, '0, {c[19:16], 16'h0});
      chk(cfg_out, c);
      chk(irq_take_out, c[18:16] & seed[24:22] & {3{c[19]}});
      chk(vector_loc_out, {c[13], 1'b1, c[6]});
      chk({group_a_word_sync_out, group_b_word_sync_out}, c[11:10]);
      chk(port_in_group_b_out, c[9] ? 7'h6e : 7'h4e);
      chk(group_a_word_bits_out, wb[{c[8], seed[21]}]);
      chk(group_b_word_bits_out, wb[{c[7], seed[20]}]);
      chk(wait_states_out, (20'h1 << c[5:4]) - 20'h1);
      chk({xfer_shift_left_out, xfer_shift_right_out},
          {(&c[2:1]) ? 2'h0 : c[2:1], &c[2:1]});
      prev = c[12];
      bus(1'b0, 3'h2, '0, {19'h0, c[19]});
      bus(1'b0, 3'h3, '0, {18'h0, c[5:4]});
      bus(1'b0, 3'h4, '0, {18'h0, c[2:1]});
    end
    bus(1'b1, 3'h0, 20'h0, '0);
    bus(1'b1, 3'h5, 20'h5ffff, '0);
    bus(1'b1, 3'h3, 20'hffffe, '0);
    bus(1'b1, 3'h4, 20'hffffd, '0);
    bus(1'b0, 3'h0, '0, 20'h50022);
    bus(1'b1, 3'h2, 20'hfffff, '0);
    bus(1'b0, 3'h5, '0, 20'hd0000);
    bus_req_in = '0;
    irq_entry_in = 1'b1;
    step(1);
    irq_entry_in = 1'b0;
    step(2);
    chk({cfg_out[19], status_out.saved_irq_enable, irq_take_out}, 5'h08);
    irq_entry_in = 1'b1;
    step(1);
    irq_entry_in = 1'b0;
    step(2);
    chk(status_out[15:8], 8'hd2);
    par_mem_strap_pin_in = 1'b0;
    vector_map_pin_in = 1'b0;
    audio_pll_reset_req_in = 1'b1;
    step(2);
    chk({status_out[15], audio_pll_reset_out}, 2'h1);
    audio_pll_reset_req_in = 1'b0;
    core_pll_reset_req_in = 1'b1;
    step(2);
    chk({status_out[12], core_pll_reset_out}, 2'h1);
    core_pll_reset_req_in = 1'b0;
    host_write_event_in = 1'b1;
    group_a_channel_side_in = 1'b0;
    group_b_channel_side_in = 1'b1;
    step(1);
    host_write_event_in = 1'b0;
    step(1);
    chk(status_out[15:8], 8'hd5);
    chk(vector_loc_out, 3'h0);
    host_irq_ack_in = 1'b1;
    group_a_channel_side_in = 1'b1;
    group_b_channel_side_in = 1'b0;
    alu_in = 7'h5a;
    step(1);
    host_irq_ack_in = 1'b0;
    alu_in = '0;
    step(1);
    chk(status_out[15:0], 16'hd29a);
    sticky_clear_in = 1'b1;
    step(1);
    sticky_clear_in = 1'b0;
    alu_in = 7'h6d;
    step(1);
    alu_in = '0;
    step(1);
    chk(status_out[7:0], 8'h0d);
    limit_event_in = 1'b1;
    xfer_valid_in = 1'b1;
    xfer_word_in = 20'h20000;
    step(1);
    limit_event_in = 1'b0;
    xfer_valid_in = 1'b0;
    step(1);
    chk(status_out[7:0], 8'h2d);
    xfer_valid_in = 1'b1;
    xfer_word_in = 20'hdffff;
    step(1);
    xfer_valid_in = 1'b0;
    step(1);
    chk(status_out[7:0], 8'h6d);
    bus(1'b1, 3'h1, 20'hfff00, '0);
    bus(1'b0, 3'h1, '0, 20'h0d200);
    bus(1'b1, 3'h6, 20'hfffff, '0);
    bus(1'b0, 3'h6, '0, 20'h0);
    bus(1'b0, 3'h7, '0, 20'h0);
    bus_req_in = '0;
    step(3);
    test_done;
  end
endmodule // dsp_mode_status_registers_tb
